// *** common/cct_pkg.sv ***
/*
 * cct_pkg: register map, field positions and state type of the capture and
 * compare timer control block. Assumes a 32-bit APB master on the core clock.
 */
package cct_pkg;
    localparam int NCH = 4;
    // byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SETUP = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h0c;
    localparam logic [7:0] OFS_CAP0 = 8'h10;
    localparam logic [7:0] OFS_CMP0 = 8'h28;
    localparam logic [7:0] OFS_CMP1 = 8'h2c;
    // control register fields
    localparam int B_ACT = 0;
    localparam int B_RUN = 1;
    localparam int B_CLR = 2;
    localparam int B_TSEL = 4;
    localparam int B_M0EN = 8;
    localparam int B_M1EN = 9;
    // per-channel byte of the capture setup register
    localparam int B_EDGE = 0;
    localparam int B_SKIP = 2;
    localparam int B_FSEL = 5;
    localparam logic [31:0] SETUP_MASK = 32'he7e7e7e7;
    localparam logic [31:0] ALL_ONES = 32'hffffffff;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    // filter needs this many stable filter ticks
    localparam logic [1:0] FILT_TICKS = 2'h3;

    typedef struct packed {
        logic act;
        logic run;
        logic clr;
        logic [2:0] tsel;
        logic m0en;
        logic m1en;
        logic [31:0] setup;
        logic [31:0] count;
        logic [1:0][31:0] cmp;
        logic [NCH-1:0][31:0] cap;
        logic [7:0] pre;
        logic [NCH-1:0] sync1;
        logic [NCH-1:0] sync2;
        logic [NCH-1:0] filt;
        logic [NCH-1:0][1:0] fcnt;
        logic [NCH-1:0] prev;
        logic [NCH-1:0] cap_stb;
        logic ovf;
        logic [1:0] match;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } cct_state_t;
endpackage

// *** rtl/cct_ctrl.sv ***
/*
 * cct_ctrl: free-running counter, compare match and four-channel input
 * capture with noise filters, reached over APB.
 * Assumes a 20 MHz core clock, a synchronous active-low reset and
 * asynchronous capture pins.
 */
`timescale 1ns/1ps
module cct_ctrl
    import cct_pkg::*;
#(
    parameter int CH = NCH
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [CH-1:0] capture_input_i,
    output logic [31:0] count_o,
    output logic activate_o,
    output logic [CH-1:0] capture_stb_o,
    output logic rollover_irq_o,
    output logic [1:0] match_irq_o
);
    // register layout serves exactly four channels
    if (CH != NCH) begin : g_chk
        $error("cct_ctrl supports only four capture channels");
    end

    cct_state_t s_q;
    cct_state_t s_d;
    logic wr;
    logic rd_setup;
    logic adv;
    logic [31:0] cnt_nx;

    // divided-rate tick: code k fires once every 2**k core cycles
    function automatic logic tick(input logic [7:0] pre, input logic [2:0] k);
        logic [7:0] m;
        m = (8'h01 << k) - 8'h01;
        return (pre & m) == m;
    endfunction

    assign wr = psel_i & penable_i & pwrite_i & s_q.pready;
    assign rd_setup = psel_i & ~penable_i;
    assign adv = s_q.run & ~s_q.clr & tick(s_q.pre, s_q.tsel);
    assign cnt_nx = s_q.count + 32'h1;

    // next-state logic for the whole block
    always_comb begin
        s_d = s_q;
        s_d.pre = s_q.pre + 8'h01;
        s_d.ovf = 1'b0;
        s_d.match = 2'b00;
        s_d.cap_stb = '0;
        // counter: clear has priority, then advance on the selected tick
        if (s_q.clr) begin
            s_d.count = '0;
            s_d.clr = 1'b0;
            s_d.run = 1'b0;
        end else if (adv) begin
            s_d.count = cnt_nx;
            s_d.ovf = (s_q.count == ALL_ONES);
            s_d.match[0] = s_q.m0en & (cnt_nx == s_q.cmp[0]);
            s_d.match[1] = s_q.m1en & (cnt_nx == s_q.cmp[1]);
        end
        // capture channels: sync, filter, edge detect, snapshot
        for (int i = 0; i < CH; i++) begin
            logic lvl;
            logic [7:0] cfg;
            lvl = 1'b0;
            cfg = s_q.setup[8*i +: 8];
            s_d.sync1[i] = capture_input_i[i];
            s_d.sync2[i] = s_q.sync1[i];
            if (tick(s_q.pre, cfg[B_FSEL +: 3])) begin
                if (s_q.sync2[i] == s_q.filt[i]) begin
                    s_d.fcnt[i] = 2'h0;
                end else if (s_q.fcnt[i] == FILT_TICKS - 2'h1) begin
                    s_d.filt[i] = s_q.sync2[i];
                    s_d.fcnt[i] = 2'h0;
                end else begin
                    s_d.fcnt[i] = s_q.fcnt[i] + 2'h1;
                end
            end
            lvl = cfg[B_SKIP] ? s_q.sync2[i] : s_q.filt[i];
            s_d.prev[i] = lvl;
            unique case (cfg[B_EDGE +: 2])
                EDGE_FALL: s_d.cap_stb[i] = s_q.prev[i] & ~lvl;
                EDGE_RISE: s_d.cap_stb[i] = ~s_q.prev[i] & lvl;
                EDGE_BOTH: s_d.cap_stb[i] = s_q.prev[i] ^ lvl;
                default: s_d.cap_stb[i] = 1'b0;
            endcase
            if (s_d.cap_stb[i]) begin
                s_d.cap[i] = s_q.count;
            end
        end
        // apb: registered answer, ready in the first access cycle
        s_d.pready = rd_setup;
        s_d.pslverr = 1'b0;
        s_d.prdata = '0;
        if (rd_setup) begin
            unique case (paddr_i)
                OFS_CTRL: begin
                    s_d.prdata[B_ACT] = s_q.act;
                    s_d.prdata[B_RUN] = s_q.run;
                    s_d.prdata[B_CLR] = s_q.clr;
                    s_d.prdata[B_TSEL +: 3] = s_q.tsel;
                    s_d.prdata[B_M0EN] = s_q.m0en;
                    s_d.prdata[B_M1EN] = s_q.m1en;
                end
                OFS_SETUP: s_d.prdata = s_q.setup;
                OFS_COUNT: s_d.prdata = s_q.count;
                OFS_CAP0: s_d.prdata = s_q.cap[0];
                OFS_CAP0 + 8'h04: s_d.prdata = s_q.cap[1];
                OFS_CAP0 + 8'h08: s_d.prdata = s_q.cap[2];
                OFS_CAP0 + 8'h0c: s_d.prdata = s_q.cap[3];
                OFS_CMP0: s_d.prdata = s_q.cmp[0];
                OFS_CMP1: s_d.prdata = s_q.cmp[1];
                default: s_d.pslverr = 1'b1;
            endcase
        end
        if (wr) begin
            unique case (paddr_i)
                OFS_CTRL: begin
                    s_d.act = pwdata_i[B_ACT];
                    s_d.run = pwdata_i[B_RUN];
                    s_d.tsel = pwdata_i[B_TSEL +: 3];
                    s_d.m0en = pwdata_i[B_M0EN];
                    s_d.m1en = pwdata_i[B_M1EN];
                    if (pwdata_i[B_CLR]) begin
                        s_d.clr = 1'b1;
                    end
                end
                OFS_SETUP: s_d.setup = pwdata_i & SETUP_MASK;
                OFS_COUNT: begin
                    if (!s_q.run && !s_q.clr) begin
                        s_d.count = pwdata_i;
                    end
                end
                OFS_CMP0: s_d.cmp[0] = pwdata_i;
                OFS_CMP1: s_d.cmp[1] = pwdata_i;
                default: s_d.act = s_q.act;
            endcase
        end
    end

    // state register, counter zero after reset
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from state flops
    assign prdata_o = s_q.prdata;
    assign pready_o = s_q.pready;
    assign pslverr_o = s_q.pslverr;
    assign count_o = s_q.count;
    assign activate_o = s_q.act;
    assign capture_stb_o = s_q.cap_stb;
    assign rollover_irq_o = s_q.ovf;
    assign match_irq_o = s_q.match;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    logic wr_cnt;
    assign wr_cnt = wr && (paddr_i == OFS_COUNT);

    property p_cnt_wr;
        wr_cnt && !s_q.run && !s_q.clr |=> s_q.count == $past(pwdata_i);
    endproperty
    a_cnt_wr: assert property (p_cnt_wr) else $error("counter write lost");

    property p_stop_hold;
        !s_q.run && !s_q.clr && !wr_cnt |=> $stable(s_q.count);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stopped counter moved");

    property p_clear;
        s_q.clr |=> s_q.count == '0 && !s_q.clr && !s_q.run;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not complete");

    property p_adv;
        adv |=> s_q.count == $past(cnt_nx);
    endproperty
    a_adv: assert property (p_adv) else $error("counter step wrong");

    property p_ovf;
        s_q.ovf |-> s_q.count == '0 && $past(s_q.count) == ALL_ONES;
    endproperty
    a_ovf: assert property (p_ovf) else $error("rollover flag wrong");

    property p_m0;
        s_q.match[0] |-> s_q.count == $past(s_q.cmp[0]) && $past(s_q.m0en);
    endproperty
    a_m0: assert property (p_m0) else $error("compare 0 flag wrong");

    property p_m1;
        s_q.match[1] |-> s_q.count == $past(s_q.cmp[1]) && $past(s_q.m1en);
    endproperty
    a_m1: assert property (p_m1) else $error("compare 1 flag wrong");

    property p_m_once;
        s_q.match[0] |=> !s_q.match[0];
    endproperty
    a_m_once: assert property (p_m_once) else $error("repeated match");

    property p_cap;
        s_q.cap_stb[0] |-> s_q.cap[0] == $past(s_q.count) && $past(s_q.setup[1:0]) != 2'h3;
    endproperty
    a_cap: assert property (p_cap) else $error("capture 0 wrong");

    cover property (s_q.ovf);
    cover property (s_q.match[0]);
    cover property (s_q.cap_stb[0] && !s_q.setup[B_SKIP]);
    cover property (s_q.clr ##1 !s_q.clr);
endmodule // cct_ctrl

// *** testbench/cct_ctrl_bench.sv ***
/* cct_ctrl_bench: self-checking bench of the timer control block.
   Assumes cct_pkg, cct_ctrl and cct_pin_model are compiled first. */
`timescale 1ns/1ps
module cct_ctrl_bench;
    import cct_pkg::*;
    logic clk_i = 0, nrst_i = 0, psel = 0, pen = 0, pwr = 0, rdy, err, roll, act;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, cnt, v, c;
    logic [3:0] lvl = 0, pins, stb;
    logic [1:0] mt;
    logic [64:0] q[$];
    logic [64:0] nt; // note taken by the monitor, kept apart from the stimulus variables
    logic [31:0] last_cap[4];
    int failures = 0, n_compared = 0, seed = 82, roll_n = 0, stb_n[4], m_n[2], s[4], m[2];
    // core clock, 50 ns
    always #25 clk_i = ~clk_i;
    cct_ctrl #(.CH(4)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(rdy),
        .pslverr_o(err), .capture_input_i(pins), .count_o(cnt), .activate_o(act),
        .capture_stb_o(stb), .rollover_irq_o(roll), .match_irq_o(mt));
    cct_pin_model pin_u (.clk_i(clk_i), .level_i(lvl), .pins_o(pins));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] sn);
        n_compared++;
        if (sn !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, sn);
        end
    endtask
    // one apb transfer; the expected answer is queued for the monitor
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] e, input logic [31:0] mk, input logic er, output logic [31:0] g);
        @(posedge clk_i);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        pen <= 1;
        q.push_back({er, mk, e});
        // wait as long as it takes; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (rdy !== 1'b1);
        g = prdata;
        psel <= 0;
        pen <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] g;
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0, g);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] g;
        apb(1'b0, a, 32'h0, e, ALL_ONES, 1'b0, g);
    endtask
    // monitor: pops the oldest note per answer, tallies pulses
    always @(posedge clk_i) begin
        if (rdy === 1'b1) begin
            if (q.size() == 0) chk("unasked answer", 0, 1);
            else begin
                nt = q.pop_front();
                chk("read data", nt[31:0] & nt[63:32], prdata & nt[63:32]);
                chk("error flag", {31'h0, nt[64]}, {31'h0, err});
            end
        end
        for (int i = 0; i < 4; i++) if (stb[i] === 1'b1) begin
            stb_n[i]++;
            last_cap[i] <= cnt - 1;
        end
        for (int i = 0; i < 2; i++) if (mt[i] === 1'b1) m_n[i]++;
        if (roll === 1'b1) roll_n++;
    end
    task automatic wrap_up;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #(20000 * 50);
        failures++;
        wrap_up;
    end
    initial begin
        repeat (10) @(posedge clk_i);
        nrst_i <= 1;
        rd(OFS_CTRL, 0);
        rd(OFS_COUNT, 0);
        rd(OFS_SETUP, 0);
        apb(1'b0, 8'h30, 32'h0, 32'h0, ALL_ONES, 1'b1, c);
        v = $random(seed);
        wr(OFS_SETUP, v);
        rd(OFS_SETUP, v & SETUP_MASK);
        wr(OFS_COUNT, 32'hfffffff0);
        rd(OFS_COUNT, 32'hfffffff0);
        wr(OFS_CTRL, 32'h2);
        wr(OFS_COUNT, 0);
        repeat (30) @(posedge clk_i);
        chk("rollovers", 1, roll_n);
        chk("wrapped", 1, cnt > 0 && cnt < 64);
        wr(OFS_CTRL, 0);
        @(posedge clk_i);
        c = cnt;
        repeat (10) @(posedge clk_i);
        chk("held count", c, cnt);
        wr(OFS_CTRL, 32'h6);
        for (int k = 0; k < 10; k++) begin
            apb(1'b0, OFS_CTRL, 32'h0, 32'h0, 32'h0, 1'b0, v);
            if (v[B_CLR] !== 1'b1) break;
        end
        chk("ctrl after clear", 0, v);
        rd(OFS_COUNT, 0);
        wr(OFS_CMP0, 32'h14);
        wr(OFS_CMP1, 32'h19);
        m = m_n;
        wr(OFS_CTRL, 32'h102);
        repeat (40) @(posedge clk_i);
        chk("match0", m[0] + 1, m_n[0]);
        chk("match1 off", m[1], m_n[1]);
        wr(OFS_CTRL, 0);
        wr(OFS_COUNT, 0);
        m = m_n;
        wr(OFS_CTRL, 32'h232);
        repeat (260) @(posedge clk_i);
        chk("match1 once", m[1] + 1, m_n[1]);
        chk("match0 off", m[0], m_n[0]);
        for (int k = 0; k < 8; k++) begin
            wr(OFS_CTRL, 0);
            wr(OFS_COUNT, 0);
            wr(OFS_CTRL, (k << 4) | 2);
            c = cnt;
            repeat (512) @(posedge clk_i);
            v = cnt - c;
            chk("tick rate", 1, v >= (512 >> k) - 1 && v <= (512 >> k) + 1);
        end
        wr(OFS_CTRL, 32'h3);
        wr(OFS_SETUP, 32'h07060504);
        s = stb_n;
        lvl <= 4'hf;
        repeat (10) @(posedge clk_i);
        lvl <= 4'h0;
        repeat (10) @(posedge clk_i);
        for (int i = 0; i < 4; i++) chk("strobes", s[i] + (i == 2) + (i < 3), stb_n[i]);
        chk("activate", 1, act);
        rd(OFS_CTRL, 32'h3);
        rd(OFS_CAP0 + 8'h04, last_cap[1]);
        rd(OFS_CAP0 + 8'h08, last_cap[2]);
        wr(OFS_SETUP, 32'h03030302);
        s = stb_n;
        lvl <= 4'h1;
        repeat (2) @(posedge clk_i);
        lvl <= 4'h0;
        repeat (10) @(posedge clk_i);
        chk("glitch", s[0], stb_n[0]);
        lvl <= 4'h1;
        repeat (12) @(posedge clk_i);
        chk("filtered", s[0] + 1, stb_n[0]);
        // slow filter clock (code 3, one tick per 8 cycles): fall needs three such ticks
        wr(OFS_SETUP, 32'h03030362);
        s = stb_n;
        lvl <= 4'h0;
        repeat (16) @(posedge clk_i);
        chk("slow filter early", s[0], stb_n[0]);
        repeat (24) @(posedge clk_i);
        chk("slow filter", s[0] + 1, stb_n[0]);
        wrap_up;
    end
endmodule // cct_ctrl_bench

// *** testbench/cct_pin_model.sv ***
/* cct_pin_model: drives the four capture pins like an outside source.
   Assumes the bench asks for pin levels just after a rising clock edge. */
`timescale 1ns/1ps
module cct_pin_model (
    input wire logic clk_i,
    input wire logic [3:0] level_i,
    output logic [3:0] pins_o
);
    // pins are asynchronous: they move mid-cycle, never on the core edge
    initial pins_o = 4'h0;
    always @(posedge clk_i) begin
        pins_o <= #13 level_i;
    end
endmodule // cct_pin_model
